// File: hdl/sffc_core.sv
// SPI frame-format core: mode register, one-byte transmit holding register, receive
// register and an eight-bit shift engine for master and slave roles.
// Assumes a byte-wide register port on the core clock; link pins are asynchronous.
//
// Functional notes
// - Mode bit 4 selects slave or master.
// - Polarity clear: clock idles low, rising first.
// - Polarity set: clock idles high, falling first.
// - Phase clear: sample odd edges, update even.
// - Phase set: update odd edges, sample even.
// - Master bit 1 picks MSB or LSB first.
// - Role, polarity, phase, order reset to zero.
// - Transfer mode bit resets to one.
// - Bit 6 enables the serial interface.
// - Continuous mode keeps select low while data.
`timescale 1ns/10ps
module sffc_core #(
  parameter int HALF_DIV = sffc_pkg::HALF_PERIOD_CYCLES,
  parameter int GAP_LEN = sffc_pkg::GAP_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata_q,
  // Configuration seen by the rest of the unit
  output sffc_pkg::sffc_cfg_t cfg_q,
  // Serial clock pin
  input wire logic sclk_in,
  output logic sclk_out_q,
  output logic sclk_oe_q,
  // Slave select pin, active low
  input wire logic ss_n_in,
  output logic ss_n_out_q,
  output logic ss_n_oe_q,
  // Serial data
  input wire logic sdi_in,
  output logic sdo_out_q,
  output logic sdo_oe_q
);
  initial begin
    if (HALF_DIV < 2 || HALF_DIV > 255 || GAP_LEN < 1 || GAP_LEN > 255) begin
      $error("sffc_core: HALF_DIV must be 2..255 and GAP_LEN 1..255");
    end
  end

  sffc_pkg::sffc_state_t state_q;
  logic [7:0] tx_q, sh_q, rx_q;
  logic tx_full_q, rx_full_q, rx_ovf_q, samp_q;
  logic [3:0] edge_q;
  logic [7:0] div_q;
  logic [2:0] sclk_s, ss_s;
  logic [1:0] sdi_s;

  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic lsbf);
    shift_in = lsbf ? {b, sh[7:1]} : {sh[6:0], b};
  endfunction : shift_in

  // Two flip-flops before use, three for select; the third clock stage only feeds edge detection.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_s <= 3'h0;
      ss_s <= 3'h7;
      sdi_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_in};
      ss_s <= {ss_s[1:0], ss_n_in};
      sdi_s <= {sdi_s[0], sdi_in};
    end
  end

  logic en, master, lsbf, cpha, sdi_b, slave_sel, link_edge, sample_now, shift_now;
  logic last_edge, start, reload, frame_done;
  logic [7:0] rx_result;
  assign en = cfg_q.serial_if_enable;
  assign master = cfg_q.master_select;
  assign lsbf = master & cfg_q.lsb_first_select;
  assign cpha = cfg_q.clock_sample_phase;
  assign sdi_b = sdi_s[1];
  assign slave_sel = ~ss_s[2];
  // Master edges come from the divider; slave edges from the synchronised pin.
  assign link_edge = (state_q == sffc_pkg::ST_RUN) &&
                     (master ? (div_q == 8'(HALF_DIV - 1)) : (sclk_s[2] ^ sclk_s[1]));
  // Edge_q counts from zero, so an even count is an odd-numbered edge.
  assign sample_now = cpha ? edge_q[0] : ~edge_q[0];
  assign shift_now = cpha ? (~edge_q[0] && edge_q != 4'h0) : edge_q[0];
  assign last_edge = link_edge && (edge_q == sffc_pkg::LAST_EDGE);
  assign rx_result = cpha ? shift_in(sh_q, sdi_b, lsbf) : shift_in(sh_q, samp_q, lsbf);
  assign start = en && (state_q == sffc_pkg::ST_IDLE) &&
                 (master ? tx_full_q : slave_sel);
  assign reload = last_edge && (master ? (cfg_q.continuous_transfer_enable && tx_full_q)
                                       : slave_sel);
  assign frame_done = last_edge;

  // Mode register and transmit holding register.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= sffc_pkg::sffc_cfg_t'(sffc_pkg::MODE_CFG_RESET);
    end else if (reg_write && reg_addr == sffc_pkg::ADDR_MODE_CFG) begin
      cfg_q <= sffc_pkg::sffc_cfg_t'(reg_wdata);
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_q <= 8'h00;
      tx_full_q <= 1'b0;
    end else if (reg_write && reg_addr == sffc_pkg::ADDR_TX_DATA) begin
      tx_q <= reg_wdata;
      tx_full_q <= 1'b1;
    end else if ((start || reload) && tx_full_q) begin
      tx_full_q <= 1'b0;
    end
  end

  // Receive register; a new byte wins over a clearing read in the same cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 8'h00;
      rx_full_q <= 1'b0;
      rx_ovf_q <= 1'b0;
    end else if (frame_done) begin
      rx_q <= rx_result;
      rx_full_q <= 1'b1;
      rx_ovf_q <= rx_ovf_q | (rx_full_q && !(reg_read && reg_addr == sffc_pkg::ADDR_RX_DATA));
    end else if (reg_read && reg_addr == sffc_pkg::ADDR_RX_DATA) begin
      rx_full_q <= 1'b0;
      rx_ovf_q <= 1'b0;
    end
  end

  // Transfer sequencer.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= sffc_pkg::ST_IDLE;
      div_q <= 8'h00;
      edge_q <= 4'h0;
      sh_q <= 8'h00;
      samp_q <= 1'b0;
    end else if (!en) begin
      state_q <= sffc_pkg::ST_IDLE;
      div_q <= 8'h00;
      edge_q <= 4'h0;
    end else begin
      case (state_q)
        sffc_pkg::ST_IDLE: begin
          div_q <= 8'h00;
          edge_q <= 4'h0;
          if (start) begin
            state_q <= sffc_pkg::ST_RUN;
            sh_q <= tx_full_q ? tx_q : sffc_pkg::IDLE_FILL;
          end
        end
        sffc_pkg::ST_RUN: begin
          div_q <= (master && div_q != 8'(HALF_DIV - 1)) ? div_q + 8'h01 : 8'h00;
          if (!master && !slave_sel) begin
            state_q <= sffc_pkg::ST_IDLE;
          end else if (link_edge) begin
            edge_q <= edge_q + 4'h1;
            if (sample_now) begin
              samp_q <= sdi_b;
            end
            if (last_edge) begin
              if (reload) begin
                sh_q <= tx_full_q ? tx_q : sffc_pkg::IDLE_FILL;
              end else begin
                state_q <= master ? sffc_pkg::ST_GAP : sffc_pkg::ST_RUN;
                div_q <= 8'h00;
              end
            end else if (shift_now) begin
              sh_q <= shift_in(sh_q, samp_q, lsbf);
            end
          end
        end
        sffc_pkg::ST_GAP: begin
          div_q <= div_q + 8'h01;
          if (div_q == 8'(GAP_LEN - 1)) begin
            state_q <= sffc_pkg::ST_IDLE;
          end
        end
        default: state_q <= sffc_pkg::ST_IDLE;
      endcase
    end
  end

  // Pin drivers, all registered.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_out_q <= 1'b0;
      sclk_oe_q <= 1'b0;
      ss_n_out_q <= 1'b1;
      ss_n_oe_q <= 1'b0;
      sdo_out_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sclk_oe_q <= en && master;
      ss_n_oe_q <= en && master;
      // The clock rests at the polarity level outside frames and toggles per edge.
      if (state_q == sffc_pkg::ST_RUN && master) begin
        sclk_out_q <= link_edge ? ~sclk_out_q : sclk_out_q;
      end else begin
        sclk_out_q <= cfg_q.clock_idle_polarity;
      end
      ss_n_out_q <= !(en && master && (start || state_q == sffc_pkg::ST_RUN));
      sdo_out_q <= lsbf ? sh_q[0] : sh_q[sffc_pkg::FRAME_BITS - 1];
      sdo_oe_q <= en && (master ? state_q == sffc_pkg::ST_RUN : slave_sel);
    end
  end

  // Register read port: data stand in the cycle after the read strobe.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        sffc_pkg::ADDR_MODE_CFG: reg_rdata_q <= cfg_q;
        sffc_pkg::ADDR_TX_DATA: reg_rdata_q <= tx_q;
        sffc_pkg::ADDR_RX_DATA: reg_rdata_q <= rx_q;
        sffc_pkg::ADDR_STATUS: begin
          reg_rdata_q <= 8'h00;
          reg_rdata_q[sffc_pkg::STAT_BUSY_BIT] <= state_q != sffc_pkg::ST_IDLE;
          reg_rdata_q[sffc_pkg::STAT_RX_OVF_BIT] <= rx_ovf_q;
          reg_rdata_q[sffc_pkg::STAT_RX_FULL_BIT] <= rx_full_q;
          reg_rdata_q[sffc_pkg::STAT_TX_FULL_BIT] <= tx_full_q;
        end
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end
endmodule : sffc_core

// File: shared/sffc_pkg.sv
// Constants, field layout and carrier types for the SPI frame-format block.
// Assumes a byte-wide register port with a two-bit word address.
package sffc_pkg;
  // Register word addresses.
  localparam logic [1:0] ADDR_MODE_CFG = 2'h0;
  localparam logic [1:0] ADDR_TX_DATA = 2'h1;
  localparam logic [1:0] ADDR_RX_DATA = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // Bit positions inside spi_mode_config.
  localparam int CFG_IRQ_MODE_BIT = 0;
  localparam int CFG_LSB_FIRST_BIT = 1;
  localparam int CFG_PHASE_BIT = 2;
  localparam int CFG_POLARITY_BIT = 3;
  localparam int CFG_MASTER_BIT = 4;
  localparam int CFG_ENABLE_BIT = 6;
  localparam int CFG_CONT_BIT = 7;
  localparam logic [7:0] MODE_CFG_RESET = 8'h01;
  // Bit positions inside the status word.
  localparam int STAT_TX_FULL_BIT = 1;
  localparam int STAT_RX_FULL_BIT = 4;
  localparam int STAT_RX_OVF_BIT = 5;
  localparam int STAT_BUSY_BIT = 7;
  // Transfer framing.
  localparam int FRAME_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam logic [7:0] IDLE_FILL = 8'hFF;
  // Master timing, in core clock cycles.
  localparam int HALF_PERIOD_CYCLES = 4;
  localparam int GAP_CYCLES = 8;

  typedef struct packed {
    logic continuous_transfer_enable;
    logic serial_if_enable;
    logic spare;
    logic master_select;
    logic clock_idle_polarity;
    logic clock_sample_phase;
    logic lsb_first_select;
    logic transfer_irq_mode;
  } sffc_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_GAP = 2'b10
  } sffc_state_t;
endpackage : sffc_pkg

// File: verification/sffc_core_asserts.sv
// Pin-level checker for the frame-format core.
// Bound to sffc_core; sees its ports only.
`timescale 1ns/10ps
module sffc_core_asserts (
  // Clock
  input wire logic clock,
  input wire logic rstn,
  // Register writes
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire sffc_pkg::sffc_cfg_t cfg_q,
  // Link
  input wire logic sclk_out_q,
  input wire logic sclk_oe_q,
  input wire logic ss_n_out_q,
  input wire logic ss_n_oe_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  logic sclk_p_q;
  logic ss_p_q;
  logic [5:0] cnt_q;
  // Counts clock toggles inside a selection, including the cycle select rises.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sclk_p_q <= 1'b0;
      ss_p_q <= 1'b1;
      cnt_q <= 6'h00;
    end else begin
      sclk_p_q <= sclk_out_q;
      ss_p_q <= ss_n_out_q;
      if (ss_n_out_q && ss_p_q) begin
        cnt_q <= 6'h00;
      end else if (sclk_out_q != sclk_p_q) begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end
  sequence quiet3;
    (ss_n_out_q && $stable(cfg_q))[*3];
  endsequence
  sequence start_s;
    $fell(ss_n_out_q);
  endsequence
  AST_IDLE_LEVEL: assert property (quiet3 ##0 sclk_oe_q |-> sclk_out_q == cfg_q.clock_idle_polarity)
    else $error("clock idle level wrong");
  AST_START_LEVEL: assert property (start_s |-> sclk_out_q == cfg_q.clock_idle_polarity ##1 $stable(sclk_out_q))
    else $error("clock moved at select");
  AST_EDGES: assert property ($rose(ss_n_out_q) |=> cnt_q[3:0] == 4'h0 && cnt_q != 6'h00)
    else $error("edge count not whole bytes");
  AST_SLAVE_QUIET: assert property (!cfg_q.master_select && !$past(cfg_q.master_select) |-> !sclk_oe_q && !ss_n_oe_q)
    else $error("slave drives clock");
  AST_DISABLED: assert property (!cfg_q.serial_if_enable && !$past(cfg_q.serial_if_enable) |-> !sclk_oe_q)
    else $error("disabled core drives");
  AST_MASTER_DRIVE: assert property (cfg_q.master_select && cfg_q.serial_if_enable && $stable(cfg_q) |-> sclk_oe_q)
    else $error("master not driving");
  AST_OE_PAIR: assert property (sclk_oe_q == ss_n_oe_q)
    else $error("enables differ");
  AST_CFG_WRITE: assert property (reg_write && reg_addr == 2'h0 |=> ((cfg_q ^ $past(reg_wdata)) & 8'hDF) == 8'h00)
    else $error("mode write lost");
endmodule : sffc_core_asserts
bind sffc_core sffc_core_asserts i_sffc_core_asserts (.clock(clock), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .cfg_q(cfg_q),
  .sclk_out_q(sclk_out_q), .sclk_oe_q(sclk_oe_q), .ss_n_out_q(ss_n_out_q), .ss_n_oe_q(ss_n_oe_q));

// File: verification/sffc_slave_model.sv
// Far-side SPI slave for a master-role core.
// Assumes the bench resolves the clock and select wires.
`timescale 1ns/10ps
module sffc_slave_model (
  // Link
  input wire logic clock,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  // Mode and data
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic [7:0] rx
);
  logic [7:0] sh;
  initial miso = 1'b0;
  // A released data line keeps changing so a stale bit never looks valid.
  always @(posedge clock) if (ss_n) miso <= ~miso;
  always @(negedge ss_n) begin
    sh = tx;
    if (!cpha) miso = tx[7];
  end
  always @(sclk) if (!ss_n) begin
    if ((sclk != cpol) ^ cpha) sh = {sh[6:0], mosi};
    else miso = sh[7];
  end
  always @(posedge ss_n) rx = sh;
endmodule : sffc_slave_model

// File: verification/sffc_core_test.sv
// Self-checking bench: core as master against the slave model.
// Assumes default divider and gap parameters.
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch %0t got %h exp %h", $time, a, b); end end
module sffc_core_test;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata, ptx, prx, b, exp_v;
  sffc_pkg::sffc_cfg_t cfg;
  logic sclk_o, sclk_oe, ss_o, ss_oe, sdo, sdo_oe, miso, sclk, ss_n;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic [15:0] seed = 16'hF94E;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int falls = 0;
  logic [7:0] expq[$];
  assign sclk = sclk_oe ? sclk_o : cfg.clock_idle_polarity;
  assign ss_n = ss_oe ? ss_o : 1'b1;
  sffc_core i_sffc_core (.clock(clock), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr), .reg_read(rd), .reg_rdata_q(rdata), .cfg_q(cfg), .sclk_in(sclk),
    .sclk_out_q(sclk_o), .sclk_oe_q(sclk_oe), .ss_n_in(ss_n), .ss_n_out_q(ss_o),
    .ss_n_oe_q(ss_oe), .sdi_in(miso), .sdo_out_q(sdo), .sdo_oe_q(sdo_oe));
  sffc_slave_model i_sffc_slave_model (.clock(clock), .sclk(sclk), .ss_n(ss_n),
    .mosi(sdo), .miso(miso), .cpol(cpol), .cpha(cpha), .tx(ptx), .rx(prx));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clock);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic wait_frame();
    int i;
    i = 0;
    while (ss_n !== 1'b0 && i < 40) begin
      @(posedge clock);
      i++;
    end
    while (ss_n !== 1'b1 && i < 400) begin
      @(posedge clock);
      i++;
    end
    repeat (2) @(posedge clock);
  endtask : wait_frame
  initial begin
    forever #25 clock = ~clock;
  end
  always @(negedge ss_n) falls++;
  // Read data stand from the cycle after the strobe until the next read; compare in that first cycle.
  always @(posedge clock) begin
    rd_q <= rd;
    cyc <= cyc + 1;
    if (rd_q) begin
      exp_v = expq.pop_front();
      `CHK(rdata, exp_v)
    end
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    ptx = 8'h00;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd_reg(sffc_pkg::ADDR_MODE_CFG, 8'h01);
    for (int m = 0; m < 8; m++) begin
      seed = lfsr(seed);
      ptx = seed[15:8];
      b = seed[7:0];
      {cpol, cpha} = m[1:0];
      wr_reg(sffc_pkg::ADDR_MODE_CFG, {4'h5, cpol, cpha, m[2], 1'b1});
      wr_reg(sffc_pkg::ADDR_TX_DATA, b);
      wait_frame();
      `CHK(prx, m[2] ? rev(b) : b)
      rd_reg(sffc_pkg::ADDR_RX_DATA, m[2] ? rev(ptx) : ptx);
      $display("mode %0d done", m);
    end
    {cpol, cpha} = 2'b00;
    falls = 0;
    seed = lfsr(seed);
    wr_reg(sffc_pkg::ADDR_MODE_CFG, 8'hD1);
    wr_reg(sffc_pkg::ADDR_TX_DATA, seed[7:0]);
    repeat (4) @(posedge clock);
    wr_reg(sffc_pkg::ADDR_TX_DATA, seed[15:8]);
    wait_frame();
    `CHK(falls, 1)
    `CHK(prx, seed[15:8])
    // Let the gap run out so the busy bit has dropped before the status read.
    repeat (8) @(posedge clock);
    rd_reg(sffc_pkg::ADDR_STATUS, 8'h30);
    rd_reg(sffc_pkg::ADDR_RX_DATA, seed[7:0]);
    rd_reg(sffc_pkg::ADDR_STATUS, 8'h00);
    $display("continuous done");
    wr_reg(sffc_pkg::ADDR_MODE_CFG, 8'h10);
    rd_reg(sffc_pkg::ADDR_MODE_CFG, 8'h10);
    repeat (2) @(posedge clock);
    `CHK(sclk_oe, 1'b0)
    `CHK(ss_oe, 1'b0)
    `CHK(sdo_oe, 1'b0)
    $display("disable done");
    print_verdict();
  end
endmodule : sffc_core_test
